//--- design/reset_cause_flags.v
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "reset_cause_defs.vh"
// Function
// [R1] resets restart at 0000h; sleep wake-ups continue at the next instruction
// [R2] power-on clears stack flags and power-on flag, sets watchdog/master-clear/instruction flags
// [R3] power-on sets timeout and powerdown flags to one
// [R4] brown-out clears brown-out and stack flags, sets clear/instruction flags, timeout, powerdown
// [R5] watchdog reset clears watchdog flag and timeout, others unchanged
// [R6] watchdog wake clears timeout and powerdown, keeps power control flags
// [R7] interrupt wake sets timeout, clears powerdown; vectors to 0004h after next instruction (the code flags this only when global_int_enable_i is set)
// [R8] master-clear reset clears its flag, leaves everything else unchanged
// [R9] master-clear in sleep also sets timeout and clears powerdown
// [R10] reset instruction clears its own flag only
// [R11] enabled stack overflow reset sets the overflow flag
// [R12] enabled stack underflow reset sets the underflow flag
// [R13] firmware clears stack flags by writing zero; hardware only sets them (the code also clears them on a brown-out)
// [R14] firmware writes one to re-arm watchdog, master-clear, instruction flags
// [R15] firmware writes one to power-on and brown-out flags after those resets
// [R16] bit 5 of power control reads zero and ignores writes
// [R17] stack fault resets only when stack fault reset enable is set
// [R18] flag updates apply while reset is held, before the first instruction
// [R19] power-on/brown-out flags untouched by other reset kinds
module reset_cause_flags
(
   input  wire                 ref_clk_i,
   input  wire                 rst_b_i,
   // reset and wake sources (asynchronous pins)
   input  wire                 brownout_i,
   input  wire                 master_clear_pin_b_i,
   input  wire                 watchdog_timer_i,
   input  wire                 int_wake_i,
   // core-side signals on this clock
   input  wire                 reset_instr_i,
   input  wire                 stack_overflow_i,
   input  wire                 stack_underflow_i,
   input  wire                 stack_fault_reset_enable_i,
   input  wire                 sleeping_i,
   input  wire                 global_int_enable_i,
   input  wire [`PC_W-1:0]     sleep_pc_i,
   // register port
   input  wire [`ADDR_W-1:0]   reg_addr_i,
   input  wire [7:0]           reg_wdata_i,
   input  wire                 reg_wr_i,
   input  wire                 reg_rd_i,
   output reg  [7:0]           reg_rdata_o,
   // to the core
   output reg                  core_reset_o,
   output reg                  restart_o,
   output reg  [`PC_W-1:0]     restart_pc_o,
   output reg                  int_vector_pending_o,
   output reg  [7:0]           power_control_o,
   output reg  [7:0]           core_status_o,
   output reg                  irq_o
);

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   wire [3:0] pin_sync;
   wire [3:0] pin_rise;
   wire       bor_s;
   wire       master_clr_s;
   wire       wdt_s;
   wire       iwk_s;

   sync_two_ff #(.WIDTH(4)) u_sync
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   ({int_wake_i, watchdog_timer_i, ~master_clear_pin_b_i, brownout_i}),
      .sync_o    (pin_sync)
   );

   assign bor_s  = pin_sync[0];
   assign master_clr_s = pin_sync[1];
   assign wdt_s  = pin_sync[2];
   assign iwk_s  = pin_sync[3];

   rise_detect #(.WIDTH(4)) u_rise
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .level_i   (pin_sync),
      .rise_o    (pin_rise)
   );

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------
   wire ev_bor;
   wire ev_master_clr;
   wire ev_wdt_rst;
   wire ev_wdt_wake;
   wire ev_int_wake;
   wire ev_instr_rst;
   wire ev_ovf;
   wire ev_unf;

   assign ev_bor        = pin_rise[0];
   assign ev_master_clr = pin_rise[1] & ~ev_bor;
   assign ev_wdt_rst    = pin_rise[2] & ~sleeping_i & ~ev_bor & ~ev_master_clr;
   assign ev_wdt_wake   = pin_rise[2] & sleeping_i & ~ev_bor & ~ev_master_clr;
   assign ev_int_wake   = pin_rise[3] & sleeping_i & ~ev_bor & ~ev_master_clr & ~pin_rise[2];
   assign ev_instr_rst  = reset_instr_i & ~ev_bor & ~ev_master_clr;
   assign ev_ovf        = stack_overflow_i & stack_fault_reset_enable_i;   // [R17]
   assign ev_unf        = stack_underflow_i & stack_fault_reset_enable_i;  // [R17]

   // ------------------------------------------------------------
   // power control and core status flags
   // ------------------------------------------------------------
   reg        por_done;
   reg  [7:0] pwr;
   reg  [7:0] sts;
   reg  [7:0] next_pwr;
   reg  [7:0] next_sts;
   wire       wr_pwr;
   wire       wr_sts;

   assign wr_pwr = reg_wr_i & (reg_addr_i == `ADDR_PWR_CTRL);
   assign wr_sts = reg_wr_i & (reg_addr_i == `ADDR_CORE_STATUS);

   always @*
   begin
      next_pwr = pwr;
      next_sts = sts;
      // firmware writes first; hardware events below take precedence
      if (wr_pwr)
      begin
         next_pwr = reg_wdata_i;                                // [R13] [R14] [R15]
      end
      if (wr_sts)
      begin
         next_sts[2:0] = reg_wdata_i[2:0];
      end
      if (ev_bor)
      begin
         next_pwr[`PC_BROWNOUT]  = 1'b0;                        // [R4]
         next_pwr[`PC_STK_OVF]   = 1'b0;                        // [R4]
         next_pwr[`PC_STK_UNF]   = 1'b0;                        // [R4]
         next_pwr[`PC_MASTER_CLR] = 1'b1;                       // [R4]
         next_pwr[`PC_RST_INSTR] = 1'b1;                        // [R4]
         next_pwr[`PC_POWER_ON]  = pwr[`PC_POWER_ON];           // [R4]
         next_pwr[`PC_WDT_RST]   = pwr[`PC_WDT_RST];            // [R4]
         next_sts[`CS_TIMEOUT]   = 1'b1;                        // [R4]
         next_sts[`CS_POWERDOWN] = 1'b1;                        // [R4]
      end
      else
      begin
         if (ev_master_clr)
         begin
            next_pwr[`PC_MASTER_CLR] = 1'b0;                    // [R8]
            if (sleeping_i)
            begin
               next_sts[`CS_TIMEOUT]   = 1'b1;                  // [R9]
               next_sts[`CS_POWERDOWN] = 1'b0;                  // [R9]
            end
         end
         if (ev_wdt_rst)
         begin
            next_pwr[`PC_WDT_RST] = 1'b0;                       // [R5]
            next_sts[`CS_TIMEOUT] = 1'b0;                       // [R5]
         end
         if (ev_wdt_wake)
         begin
            next_sts[`CS_TIMEOUT]   = 1'b0;                     // [R6]
            next_sts[`CS_POWERDOWN] = 1'b0;                     // [R6]
         end
         if (ev_int_wake)
         begin
            next_sts[`CS_TIMEOUT]   = 1'b1;                     // [R7]
            next_sts[`CS_POWERDOWN] = 1'b0;                     // [R7]
         end
         if (ev_instr_rst)
         begin
            next_pwr[`PC_RST_INSTR] = 1'b0;                     // [R10]
         end
      end
      if (ev_ovf)
      begin
         next_pwr[`PC_STK_OVF] = 1'b1;                          // [R11]
      end
      if (ev_unf)
      begin
         next_pwr[`PC_STK_UNF] = 1'b1;                          // [R12]
      end
      next_pwr[`PC_UNUSED] = 1'b0;                              // [R16]
   end

   // power-on is the root reset: only it loads the power-on pattern
   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pwr      <= `PC_POR_VALUE;                             // [R2] [R19]
         sts      <= `CS_POR_VALUE;                             // [R3]
         por_done <= 1'b0;
      end
      else
      begin
         pwr      <= next_pwr;                                  // [R19]
         sts      <= next_sts;
         por_done <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // core reset, restart address and interrupt vectoring
   // ------------------------------------------------------------
   wire any_reset;
   wire any_wake;

   assign any_reset = ev_bor | ev_master_clr | ev_wdt_rst | ev_instr_rst | ev_ovf | ev_unf;
   assign any_wake  = ev_wdt_wake | ev_int_wake;

   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         core_reset_o         <= 1'b1;
         restart_o            <= 1'b0;
         restart_pc_o         <= `RESET_VECTOR;
         int_vector_pending_o <= 1'b0;
      end
      else
      begin
         // reset held while the flags settle, and while a held brown-out or master-clear stays active
         core_reset_o <= ~por_done | any_reset | bor_s | master_clr_s;  // [R18]
         restart_o    <= any_reset | any_wake;
         if (any_reset)
         begin
            restart_pc_o         <= `RESET_VECTOR;              // [R1]
            int_vector_pending_o <= 1'b0;
         end
         else if (any_wake)
         begin
            restart_pc_o         <= sleep_pc_i + {{(`PC_W-1){1'b0}}, 1'b1};  // [R1]
            // core runs the next instruction, then vectors to the interrupt address only on an interrupt wake with global interrupts enabled
            int_vector_pending_o <= ev_int_wake & global_int_enable_i;        // [R7]
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   reg  [`EV_N-1:0] irq_status;
   reg  [`EV_N-1:0] irq_mask;
   wire [`EV_N-1:0] ev_vec;

   assign ev_vec = {ev_int_wake, ev_wdt_wake, ev_ovf | ev_unf, ev_instr_rst, ev_master_clr, ev_wdt_rst, ev_bor, 1'b0};

   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_status <= {{(`EV_N-1){1'b0}}, 1'b1};
         irq_mask   <= {`EV_N{1'b0}};
         irq_o      <= 1'b0;
      end
      else
      begin
         // a set in the same cycle as a write-one clear wins
         if (reg_wr_i && reg_addr_i == `ADDR_IRQ_STATUS)
            irq_status <= (irq_status & ~reg_wdata_i) | ev_vec;
         else
            irq_status <= irq_status | ev_vec;
         if (reg_wr_i && reg_addr_i == `ADDR_IRQ_MASK)
            irq_mask <= reg_wdata_i;
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------
   // register read and mirrors
   // ------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         reg_rdata_o     <= 8'h00;
         power_control_o <= `PC_POR_VALUE;
         core_status_o   <= `CS_POR_VALUE;
      end
      else
      begin
         power_control_o <= pwr;
         core_status_o   <= sts;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `ADDR_PWR_CTRL:    reg_rdata_o <= pwr;
               `ADDR_CORE_STATUS: reg_rdata_o <= {3'h0, sts[4:0]};
               `ADDR_IRQ_STATUS:  reg_rdata_o <= irq_status;
               `ADDR_IRQ_MASK:    reg_rdata_o <= irq_mask;
               default:           reg_rdata_o <= 8'h00;
            endcase
         end
         else
         begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

endmodule // reset_cause_flags

//--- common/reset_cause_defs.vh
`ifndef RESET_CAUSE_DEFS_VH
`define RESET_CAUSE_DEFS_VH

// register addresses on the plain register port
`define ADDR_W            3
`define ADDR_PWR_CTRL     3'h0
`define ADDR_CORE_STATUS  3'h1
`define ADDR_IRQ_STATUS   3'h2
`define ADDR_IRQ_MASK     3'h3

// power control field positions
`define PC_STK_OVF        7
`define PC_STK_UNF        6
`define PC_UNUSED         5
`define PC_WDT_RST        4
`define PC_MASTER_CLR     3
`define PC_RST_INSTR      2
`define PC_POWER_ON       1
`define PC_BROWNOUT       0

// core status field positions
`define CS_TIMEOUT        4
`define CS_POWERDOWN      3

// reset values
`define PC_POR_VALUE      8'h1C
`define CS_POR_VALUE      8'h18

// program counter
`define PC_W              10
`define RESET_VECTOR      10'h000
`define INT_VECTOR        10'h004

// event codes (interrupt status bit positions)
`define EV_POR            0
`define EV_BOR            1
`define EV_WDT            2
`define EV_MASTER_CLR     3
`define EV_RST_INSTR      4
`define EV_STACK          5
`define EV_WAKE_WDT       6
`define EV_WAKE_INT       7
`define EV_N              8

`endif

//--- design/sync_two_ff.v
`timescale 1ns/10ps
// ------------------------------------------------------------
// two flip-flop synchroniser
// ------------------------------------------------------------
module sync_two_ff
#(
   parameter WIDTH = 1
)
(
   input  wire             ref_clk_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] async_i,
   output reg  [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta;

   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta   <= {WIDTH{1'b0}};
         sync_o <= {WIDTH{1'b0}};
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule // sync_two_ff

//--- design/rise_detect.v
`timescale 1ns/10ps
// ------------------------------------------------------------
// rising edge detector per bit
// ------------------------------------------------------------
module rise_detect
#(
   parameter WIDTH = 1
)
(
   input  wire             ref_clk_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] level_i,
   output wire [WIDTH-1:0] rise_o
);

   reg [WIDTH-1:0] last;

   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         last <= {WIDTH{1'b0}};
      else
         last <= level_i;
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_rise
         assign rise_o[g] = level_i[g] & ~last[g];
      end
   endgenerate

endmodule // rise_detect

//--- tb/reset_cause_flags_checker.sv
`timescale 1ns/10ps
`include "reset_cause_defs.vh"
// ------------------------------------------------------------
// reset cause checker
// ------------------------------------------------------------
module reset_cause_flags_checker
(
   input logic             ref_clk_i,
   input logic             rst_b_i,
   input logic [2:0]       reg_addr_i,
   input logic             reg_wr_i,
   input logic             reg_rd_i,
   input logic [7:0]       reg_rdata_o,
   input logic             reset_instr_i,
   input logic             stack_overflow_i,
   input logic             stack_underflow_i,
   input logic             stack_fault_reset_enable_i,
   input logic             core_reset_o,
   input logic             restart_o,
   input logic [9:0]       restart_pc_o,
   input logic [7:0]       power_control_o,
   input logic [7:0]       core_status_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence instr_reset_s;
      reset_instr_i ##1 restart_o;
   endsequence

   // the flag mirror trails the flag register by one cycle
   sequence ovf_idle_s;
      (!stack_fault_reset_enable_i && !reg_wr_i) ##1 !power_control_o[7];
   endsequence

   instr_restart_a: assert property (instr_reset_s |-> restart_pc_o == `RESET_VECTOR && core_reset_o)
      else $error("reset instruction did not restart at zero");
   instr_flag_a: assert property (reset_instr_i |-> ##2 !power_control_o[`PC_RST_INSTR])
      else $error("reset instruction flag not cleared");
   ovf_set_a: assert property (stack_overflow_i && stack_fault_reset_enable_i |-> ##2 power_control_o[7])
      else $error("overflow flag not set");
   unf_set_a: assert property (stack_underflow_i && stack_fault_reset_enable_i |-> ##2 power_control_o[6])
      else $error("underflow flag not set");
   stack_gate_a: assert property (ovf_idle_s |=> !power_control_o[7])
      else $error("overflow flag set while disabled");
   unused_bit_a: assert property (!power_control_o[`PC_UNUSED])
      else $error("unused bit not zero");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data outside read slot");
   unmapped_read_a: assert property (reg_rd_i && reg_addr_i[2] |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   por_status_a: assert property ($rose(rst_b_i) |-> core_status_o[4:3] == 2'b11)
      else $error("status flags not set after power-on");
endmodule // reset_cause_flags_checker

bind reset_cause_flags reset_cause_flags_checker reset_cause_flags_checker_i
(
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reset_instr_i(reset_instr_i),
   .stack_overflow_i(stack_overflow_i), .stack_underflow_i(stack_underflow_i),
   .stack_fault_reset_enable_i(stack_fault_reset_enable_i), .core_reset_o(core_reset_o),
   .restart_o(restart_o), .restart_pc_o(restart_pc_o), .power_control_o(power_control_o),
   .core_status_o(core_status_o)
);

//--- tb/reset_cause_flags_tb.sv
`timescale 1ns/10ps
`include "reset_cause_defs.vh"
module reset_cause_flags_tb;
   logic       ref_clk_i = 0, rst_b_i = 0, brownout_i = 0, master_clear_pin_b_i = 1;
   logic       watchdog_timer_i = 0, int_wake_i = 0, reset_instr_i = 0, stack_overflow_i = 0;
   logic       stack_underflow_i = 0, stack_fault_reset_enable_i = 0, sleeping_i = 0;
   logic       global_int_enable_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic [9:0] sleep_pc_i = 10'h155;
   logic [2:0] reg_addr_i = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o, power_control_o, core_status_o;
   logic [9:0] restart_pc_o;
   logic       core_reset_o, restart_o, int_vector_pending_o, irq_o;
   int         mismatches = 0;
   int         samples_checked = 0;

   reset_cause_flags reset_cause_flags_i
   (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .brownout_i(brownout_i),
      .master_clear_pin_b_i(master_clear_pin_b_i), .watchdog_timer_i(watchdog_timer_i),
      .int_wake_i(int_wake_i), .reset_instr_i(reset_instr_i), .stack_overflow_i(stack_overflow_i),
      .stack_underflow_i(stack_underflow_i), .stack_fault_reset_enable_i(stack_fault_reset_enable_i),
      .sleeping_i(sleeping_i), .global_int_enable_i(global_int_enable_i), .sleep_pc_i(sleep_pc_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .core_reset_o(core_reset_o), .restart_o(restart_o),
      .restart_pc_o(restart_pc_o), .int_vector_pending_o(int_vector_pending_o),
      .power_control_o(power_control_o), .core_status_o(core_status_o), .irq_o(irq_o)
   );

   initial
   begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(n, {2'b00, reg_rdata_o}, {2'b00, e});
   endtask

   task flags(input logic [7:0] p, input logic [7:0] s);
      chk("power_control", {2'b00, power_control_o}, {2'b00, p});
      chk("core_status", {2'b00, core_status_o}, {2'b00, s});
   endtask

   // one pin event: assert, hold, release, settle
   task ev(input int k, input logic slp);
      @(posedge ref_clk_i);
      sleeping_i <= slp;
      global_int_enable_i <= (k == 3);
      case (k)
         0: brownout_i <= 1'b1;
         1: master_clear_pin_b_i <= 1'b0;
         2: watchdog_timer_i <= 1'b1;
         default: int_wake_i <= 1'b1;
      endcase
      step(6);
      @(posedge ref_clk_i);
      brownout_i <= 1'b0;
      master_clear_pin_b_i <= 1'b1;
      watchdog_timer_i <= 1'b0;
      int_wake_i <= 1'b0;
      step(6);
   endtask

   task stk(input logic en, input logic ovf, input logic unf, input logic [7:0] p);
      @(posedge ref_clk_i);
      stack_fault_reset_enable_i <= en;
      stack_overflow_i <= ovf;
      stack_underflow_i <= unf;
      @(posedge ref_clk_i);
      stack_overflow_i <= 1'b0;
      stack_underflow_i <= 1'b0;
      step(2);
      flags(p, 8'h18);
   endtask

   task t_por;
      flags(8'h1C, 8'h18);
      chk("core_idle", core_reset_o, 10'h000);
      rd(`ADDR_PWR_CTRL, 8'h1C, "pwr_read");
      rd(`ADDR_IRQ_STATUS, 8'h01, "irq_status");
      rd(3'h5, 8'h00, "unmapped");
      wr(`ADDR_PWR_CTRL, 8'hFF);
      rd(`ADDR_PWR_CTRL, 8'hDF, "pwr_rearm");
      wr(`ADDR_PWR_CTRL, 8'h1F);
      rd(`ADDR_PWR_CTRL, 8'h1F, "pwr_stack_clear");
   endtask

   task t_instr;
      @(posedge ref_clk_i);
      reset_instr_i <= 1'b1;
      @(posedge ref_clk_i);
      reset_instr_i <= 1'b0;
      #1;
      chk("restart", restart_o, 10'h001);
      chk("restart_pc", restart_pc_o, `RESET_VECTOR);
      chk("core_reset", core_reset_o, 10'h001);
      step(2);
      flags(8'h1B, 8'h18);
      wr(`ADDR_PWR_CTRL, 8'h1F);
   endtask

   task t_stack;
      stk(1'b0, 1'b1, 1'b0, 8'h1F);
      stk(1'b1, 1'b1, 1'b0, 8'h9F);
      stk(1'b1, 1'b0, 1'b1, 8'hDF);
   endtask

   task t_pins;
      ev(0, 1'b0);
      flags(8'h1E, 8'h18);
      ev(2, 1'b0);
      flags(8'h0E, 8'h08);
      ev(1, 1'b1);
      flags(8'h06, 8'h10);
      ev(2, 1'b1);
      flags(8'h06, 8'h00);
      chk("wake_pc", restart_pc_o, sleep_pc_i + 10'h001);
      wr(`ADDR_PWR_CTRL, 8'h1F);
      ev(1, 1'b0);
      flags(8'h17, 8'h00);
      ev(3, 1'b1);
      flags(8'h17, 8'h10);
      chk("int_pc", restart_pc_o, sleep_pc_i + 10'h001);
      chk("int_vector", int_vector_pending_o, 10'h001);
   endtask

   task t_irq;
      rd(`ADDR_IRQ_STATUS, 8'hFF, "irq_all");
      chk("irq_masked", irq_o, 10'h000);
      wr(`ADDR_IRQ_MASK, 8'h80);
      step(2);
      chk("irq_set", irq_o, 10'h001);
      wr(`ADDR_IRQ_STATUS, 8'h80);
      step(2);
      chk("irq_clear", irq_o, 10'h000);
      rd(`ADDR_IRQ_STATUS, 8'h7F, "irq_w1c");
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      step(3);
      t_por;
      t_instr;
      t_stack;
      t_pins;
      t_irq;
      end_of_test;
   end

   initial
   begin
      repeat (3000) @(posedge ref_clk_i);
      mismatches++;
      end_of_test;
   end
endmodule // reset_cause_flags_tb
